// *** core/bcl_regs.sv ***
`timescale 1ns/1ps
module bcl_regs (
	input  wire logic                  i_clk,
	input  wire logic                  i_resetn,
	input  wire logic                  i_reg_we,
	input  wire logic                  i_reg_re,
	input  wire logic [7:0]            i_reg_addr,
	input  wire logic [7:0]            i_reg_wdata,
	output logic      [7:0]            o_reg_rdata,
	input  wire logic                  i_en_pin,
	input  wire logic                  i_sel_pin,
	input  wire logic                  i_mode_sig,
	input  wire logic                  i_thermal_shutdown,
	input  wire logic                  i_short_circuit_fault,
	input  wire bcl_pkg::bcl_ramp_req_s i_ramp_req,
	output logic                       o_setpoint_sel,
	output logic                       o_low_iq,
	output logic                       o_full_sleep,
	output logic                       o_forced_pwm,
	output logic                       o_converter_on,
	output logic                       o_power_up_start,
	output logic      [6:0]            o_thermal_warn_c,
	output logic      [6:0]            o_coil_limit_da,
	output logic                       o_ramp_active,
	output logic [bcl_pkg::CODE_W-1:0] o_setpoint_code
);

	bcl_pkg::bcl_cmd_s   cmd_q;
	bcl_pkg::bcl_lim_s   lim_q;
	bcl_pkg::bcl_fault_e fault_q;
	logic [2:0]          en_sync_q;
	logic [2:0]          sel_sync_q;
	logic                en_q;
	logic                sel_q;
	logic                fault_in;
	logic                wr_cmd;
	logic                wr_lim;
	logic                soft_rst;
	logic [7:0]          step_cnt_q;
	logic [7:0]          step_period;
	logic [1:0]          speed_q;
	logic [bcl_pkg::CODE_W-1:0] target_q;
	logic                step_due;
	logic                step_lands;

	// Write decode; a soft reset write stores nothing else
	assign wr_cmd   = i_reg_we && (i_reg_addr == bcl_pkg::CMD_ADDR);
	assign wr_lim   = i_reg_we && (i_reg_addr == bcl_pkg::LIM_ADDR);
	assign soft_rst = wr_lim && i_reg_wdata[bcl_pkg::LIM_SWRST_BIT];
	assign fault_in = i_thermal_shutdown || i_short_circuit_fault;

	// Pin synchronisers: three stages, accept when last two agree
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			en_sync_q  <= 3'h0;
			sel_sync_q <= 3'h0;
		end
		else
		begin
			en_sync_q  <= {en_sync_q[1:0], i_en_pin};
			sel_sync_q <= {sel_sync_q[1:0], i_sel_pin};
		end
	end

	// Filtered pin levels, held while stages two and three differ
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			en_q  <= 1'b0;
			sel_q <= 1'b0;
		end
		else
		begin
			if (en_sync_q[1] == en_sync_q[2])
				en_q <= en_sync_q[2];
			if (sel_sync_q[1] == sel_sync_q[2])
				sel_q <= sel_sync_q[2];
		end
	end

	// Command register; spare bits masked so they read zero
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			cmd_q <= bcl_pkg::CMD_RESET;
		else if (soft_rst)
			cmd_q <= bcl_pkg::CMD_RESET;
		else if (wr_cmd)
			cmd_q <= i_reg_wdata & bcl_pkg::CMD_WR_MASK;
	end

	// Limits register; indicator reloads on any register reset
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			lim_q <= bcl_pkg::LIM_RESET;
		else if (soft_rst)
			lim_q <= bcl_pkg::LIM_RESET;
		else if (wr_lim)
			lim_q <= i_reg_wdata & bcl_pkg::LIM_WR_MASK;
	end

	// Registered read port; unmapped addresses return zero
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_reg_rdata <= 8'h00;
		else if (i_reg_re)
		begin
			unique case (i_reg_addr)
				bcl_pkg::CMD_ADDR: o_reg_rdata <= cmd_q;
				bcl_pkg::LIM_ADDR: o_reg_rdata <= lim_q;
				default:           o_reg_rdata <= 8'h00;
			endcase
		end
	end

	// Setpoint selection and idle power state from pins
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_setpoint_sel <= 1'b1;
			o_low_iq       <= 1'b0;
			o_full_sleep   <= 1'b0;
		end
		else
		begin
			// Ignored pin falls back to the high setpoint bank
			o_setpoint_sel <= cmd_q.select_pin_gate ? sel_q : 1'b1;
			o_low_iq       <= !en_q && !sel_q && !cmd_q.sleep_force;
			o_full_sleep   <= !en_q && !sel_q && cmd_q.sleep_force;
		end
	end

	// Switching mode; the ramp setting overrides the mode signal
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_forced_pwm <= 1'b0;
		else if (o_ramp_active)
			o_forced_pwm <= cmd_q.ramp_switch_mode;
		else if (i_mode_sig)
			o_forced_pwm <= cmd_q.high_forced;
		else
			o_forced_pwm <= cmd_q.low_forced;
	end

	// Thermal warning threshold decoder, registered; the warning
	// comparator sees a new level one cycle after the write lands
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_thermal_warn_c <= bcl_pkg::THERM_C_0;
		else
		begin
			unique case (lim_q.thermal_warn_level)
				2'h0: o_thermal_warn_c <= bcl_pkg::THERM_C_0;
				2'h1: o_thermal_warn_c <= bcl_pkg::THERM_C_1;
				2'h2: o_thermal_warn_c <= bcl_pkg::THERM_C_2;
				2'h3: o_thermal_warn_c <= bcl_pkg::THERM_C_3;
			endcase
		end
	end

	// Coil current limit decoder, registered; a soft reset drops the
	// limit back to its lowest setting
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_coil_limit_da <= bcl_pkg::COIL_DA_0;
		else
		begin
			unique case (lim_q.coil_current_limit)
				2'h0: o_coil_limit_da <= bcl_pkg::COIL_DA_0;
				2'h1: o_coil_limit_da <= bcl_pkg::COIL_DA_1;
				2'h2: o_coil_limit_da <= bcl_pkg::COIL_DA_2;
				2'h3: o_coil_limit_da <= bcl_pkg::COIL_DA_3;
			endcase
		end
	end

	// Fault state; registers are left alone on a restart, so the
	// host need not reprogram after a thermal or short trip
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			fault_q <= bcl_pkg::FLT_RUN;
		else
		begin
			unique case (fault_q)
				// A fault at any level trips the converter at once
				bcl_pkg::FLT_RUN:
					if (fault_in)
						fault_q <= bcl_pkg::FLT_TRIPPED;
				// Wait for the fault to clear before deciding
				bcl_pkg::FLT_TRIPPED:
					if (!fault_in)
					begin
						if (lim_q.restart_after_fault)
							fault_q <= bcl_pkg::FLT_RUN;
						else
							fault_q <= bcl_pkg::FLT_HALTED;
					end
				// Only a power-on reset leaves this state
				bcl_pkg::FLT_HALTED:
					fault_q <= bcl_pkg::FLT_HALTED;
				default:
					fault_q <= bcl_pkg::FLT_HALTED;
			endcase
		end
	end

	// Restart pulse for the cycle the tripped state hands back to
	// run; it marks the new power-up sequence
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_power_up_start <= 1'b0;
		else
			o_power_up_start <= (fault_q == bcl_pkg::FLT_TRIPPED) &&
				!fault_in && lim_q.restart_after_fault;
	end

	assign o_converter_on = (fault_q == bcl_pkg::FLT_RUN);

	// Step period doubles with each speed code
	assign step_period = bcl_pkg::STEP_BASE << speed_q;

	// Step strobe: a full period of the chosen speed has run out
	assign step_due = o_ramp_active &&
		(step_cnt_q == step_period - 8'h01);

	// The coming step lands on the target
	assign step_lands = (o_setpoint_code + 7'h01 == target_q) ||
		(o_setpoint_code - 7'h01 == target_q);

	// Request capture; a start mid-ramp redirects it at once, so the
	// host need not wait for a running ramp to finish
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			target_q <= '0;
			speed_q  <= 2'h0;
		end
		else if (i_ramp_req.start)
		begin
			target_q <= i_ramp_req.target;
			speed_q  <= i_ramp_req.speed;
		end
	end

	// Step timer, cleared on a start so the first step lands one
	// full period after the request edge
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			step_cnt_q <= 8'h00;
		else if (i_ramp_req.start || step_due)
			step_cnt_q <= 8'h00;
		else if (o_ramp_active)
			step_cnt_q <= step_cnt_q + 8'h01;
	end

	// Setpoint code, one code per step toward the target; a start
	// in the step cycle wins and leaves the code where it is
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_setpoint_code <= '0;
		else if (step_due && !i_ramp_req.start)
		begin
			if (o_setpoint_code < target_q)
				o_setpoint_code <= o_setpoint_code + 7'h01;
			else
				o_setpoint_code <= o_setpoint_code - 7'h01;
		end
	end

	// Ramp flag; a start aimed at the present code never raises it
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_ramp_active <= 1'b0;
		else if (i_ramp_req.start)
			o_ramp_active <= (i_ramp_req.target != o_setpoint_code);
		else if (step_due && step_lands)
			o_ramp_active <= 1'b0;
	end

endmodule

// *** core/bcl_pkg.sv ***
package bcl_pkg;

	// Register indices on the serial control bus
	localparam logic [7:0] CMD_ADDR = 8'h14;
	localparam logic [7:0] LIM_ADDR = 8'h16;

	// Writable bits; spare positions are held at zero
	localparam logic [7:0] CMD_WR_MASK = 8'hF1;
	localparam logic [7:0] LIM_WR_MASK = 8'hF3;

	// Field positions
	localparam int CMD_GATE_BIT   = 0;
	localparam int CMD_SLEEP_BIT  = 4;
	localparam int CMD_RAMP_BIT   = 5;
	localparam int CMD_HIGH_BIT   = 6;
	localparam int CMD_LOW_BIT    = 7;
	localparam int LIM_RESTART_AFTER_FAULT_BIT  = 0;
	localparam int LIM_IND_BIT    = 1;
	localparam int LIM_SWRST_BIT  = 2;
	localparam int LIM_THERM_LSB  = 4;
	localparam int LIM_COIL_LSB   = 6;

	// Reset values; indicator bit loads as one
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [7:0] LIM_RESET = 8'h02;

	// Thermal warning thresholds in degrees C
	localparam logic [6:0] THERM_C_0 = 7'd83;
	localparam logic [6:0] THERM_C_1 = 7'd94;
	localparam logic [6:0] THERM_C_2 = 7'd105;
	localparam logic [6:0] THERM_C_3 = 7'd116;

	// Coil current limits in tenths of an ampere
	localparam logic [6:0] COIL_DA_0 = 7'd52;
	localparam logic [6:0] COIL_DA_1 = 7'd58;
	localparam logic [6:0] COIL_DA_2 = 7'd62;
	localparam logic [6:0] COIL_DA_3 = 7'd68;

	// Ramp timing: fastest step period, clock rate
	localparam int CLK_MHZ      = 40;
	localparam int STEP_FAST_PS = 333000;
	localparam int STEP_CYCLES  = (STEP_FAST_PS * CLK_MHZ) / 1000000;
	localparam logic [7:0] STEP_BASE = 8'(STEP_CYCLES);

	// Setpoint code width (6.25 mV per code)
	localparam int CODE_W = 7;

	typedef struct packed {
		logic low_forced;
		logic high_forced;
		logic ramp_switch_mode;
		logic sleep_force;
		logic [2:0] spare;
		logic select_pin_gate;
	} bcl_cmd_s;

	typedef struct packed {
		logic [1:0] coil_current_limit;
		logic [1:0] thermal_warn_level;
		logic spare;
		logic software_reset;
		logic reset_indicator;
		logic restart_after_fault;
	} bcl_lim_s;

	typedef struct packed {
		logic       start;
		logic [1:0] speed;
		logic [CODE_W-1:0] target;
	} bcl_ramp_req_s;

	typedef enum logic [1:0] {
		FLT_RUN,
		FLT_TRIPPED,
		FLT_HALTED
	} bcl_fault_e;

endpackage

// *** verification/bcl_regs_sva.sv ***
`timescale 1ns/1ps
module bcl_regs_chk (
	input wire logic                   i_clk,
	input wire logic                   i_resetn,
	input wire logic                   i_reg_re,
	input wire logic [7:0]             o_reg_rdata,
	input wire logic                   i_thermal_shutdown,
	input wire logic                   i_short_circuit_fault,
	input wire bcl_pkg::bcl_ramp_req_s i_ramp_req,
	input wire logic                   o_low_iq,
	input wire logic                   o_full_sleep,
	input wire logic                   o_converter_on,
	input wire logic                   o_power_up_start,
	input wire logic [6:0]             o_thermal_warn_c,
	input wire logic [6:0]             o_coil_limit_da,
	input wire logic                   o_ramp_active,
	input wire logic [6:0]             o_setpoint_code
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	AST_RD_HOLD: assert property (!i_reg_re |=> $stable(o_reg_rdata))
		else $error("read data moved without a read");
	AST_SLEEP: assert property (!(o_low_iq && o_full_sleep))
		else $error("low-Iq and sleep both active");
	AST_THERM: assert property (o_thermal_warn_c inside
		{7'h53, 7'h5E, 7'h69, 7'h74})
		else $error("thermal threshold off the table");
	AST_COIL: assert property (o_coil_limit_da inside
		{7'h34, 7'h3A, 7'h3E, 7'h44})
		else $error("coil limit off the table");
	AST_TRIP: assert property (o_converter_on && (i_thermal_shutdown
		|| i_short_circuit_fault) |=> !o_converter_on)
		else $error("fault did not stop the converter");
	AST_PWRUP: assert property (o_power_up_start
		== $rose(o_converter_on))
		else $error("power-up pulse not tied to restart");
	AST_STEP: assert property ($changed(o_setpoint_code) |->
		$past(o_ramp_active) && (o_setpoint_code - $past(o_setpoint_code)
		inside {7'h01, 7'h7F}))
		else $error("setpoint moved by other than one code");
	AST_GAP: assert property ($changed(o_setpoint_code) |=>
		$stable(o_setpoint_code) [*8])
		else $error("ramp steps too close");
	AST_START: assert property (i_ramp_req.start && i_ramp_req.target
		!= o_setpoint_code |=> o_ramp_active)
		else $error("ramp did not start");
endmodule

bind bcl_regs bcl_regs_chk chk_u (.i_clk(i_clk), .i_resetn(i_resetn),
	.i_reg_re(i_reg_re), .o_reg_rdata(o_reg_rdata),
	.i_thermal_shutdown(i_thermal_shutdown),
	.i_short_circuit_fault(i_short_circuit_fault),
	.i_ramp_req(i_ramp_req), .o_low_iq(o_low_iq),
	.o_full_sleep(o_full_sleep), .o_converter_on(o_converter_on),
	.o_power_up_start(o_power_up_start),
	.o_thermal_warn_c(o_thermal_warn_c), .o_coil_limit_da(o_coil_limit_da),
	.o_ramp_active(o_ramp_active), .o_setpoint_code(o_setpoint_code));

// *** verification/bcl_host.sv ***
`timescale 1ns/1ps
module bcl_host (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_rdata,
	output logic            o_we,
	output logic            o_re,
	output logic [7:0]      o_addr,
	output logic [7:0]      o_wdata
);
	initial {o_we, o_re, o_addr, o_wdata} = 18'h00000;
	// Whole byte writes; clearing the indicator is up to the caller
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		#2 {o_we, o_addr, o_wdata} = {1'b1, a, d};
		@(posedge i_clk);
		#2 o_we = 1'b0;
		o_wdata = ~d; // Stale data is not left on the bus
	endtask
	// Data is registered, so it is taken one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge i_clk);
		#2 {o_re, o_addr} = {1'b1, a};
		@(posedge i_clk);
		#2 o_re = 1'b0;
		q = i_rdata;
	endtask
endmodule

// *** verification/buck_command_limit_regs_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module buck_command_limit_regs_tb;
	logic                  i_clk = 1'b0;
	logic                  i_resetn = 1'b0;
	logic                  we, re, en = 1'b0, sel = 1'b0, msig = 1'b0;
	logic                  thermal_shutdown = 1'b0, isc = 1'b0;
	logic [7:0]            addr, wdata, rdata, q;
	bcl_pkg::bcl_ramp_req_s ramp = '0;
	logic                  ssel, liq, slp, fpwm, conv, pup, ract;
	logic [6:0]            therm, coil, code;
	logic [6:0]            tt [4] = '{7'h53, 7'h5E, 7'h69, 7'h74};
	logic [6:0]            cc [4] = '{7'h34, 7'h3A, 7'h3E, 7'h44};
	int                    failures = 0;
	int                    tests_run = 0;
	always #12.5 i_clk = ~i_clk;
	bcl_host host_u (.i_clk(i_clk), .i_rdata(rdata), .o_we(we), .o_re(re),
		.o_addr(addr), .o_wdata(wdata));
	bcl_regs dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_reg_we(we),
		.i_reg_re(re), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata), .i_en_pin(en), .i_sel_pin(sel),
		.i_mode_sig(msig), .i_thermal_shutdown(thermal_shutdown),
		.i_short_circuit_fault(isc), .i_ramp_req(ramp),
		.o_setpoint_sel(ssel), .o_low_iq(liq), .o_full_sleep(slp),
		.o_forced_pwm(fpwm), .o_converter_on(conv), .o_power_up_start(pup),
		.o_thermal_warn_c(therm), .o_coil_limit_da(coil),
		.o_ramp_active(ract), .o_setpoint_code(code));
	task automatic report_and_stop;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Lands just after an edge so outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#2;
	endtask
	// Guard against a hang anywhere in the sequence
	initial
	begin
		#1000000;
		failures++;
		report_and_stop();
	end
	initial
	begin
		cyc(2);
		i_resetn = 1'b1;
		host_u.rd(8'h14, q); `CHK(q, bcl_pkg::CMD_RESET)
		host_u.rd(8'h16, q); `CHK(q[1], 1'b1)
		host_u.wr(8'h15, 8'hFF);
		host_u.rd(8'h15, q); `CHK(q, 8'h00)
		host_u.wr(8'h14, 8'hFF);
		host_u.rd(8'h14, q); `CHK(q, 8'hF1)
		host_u.wr(8'h16, 8'hF9);
		host_u.rd(8'h16, q); `CHK(q, 8'hF1)
		for (int k = 0; k < 4; k++)
		begin
			host_u.wr(8'h16, {k[1:0], k[1:0], 4'h1});
			cyc(2); `CHK(therm, tt[k])
			`CHK(coil, cc[k])
		end
		host_u.wr(8'h14, 8'hF1);
		host_u.wr(8'h16, 8'h04);
		host_u.rd(8'h14, q); `CHK(q, 8'h00)
		host_u.rd(8'h16, q); `CHK(q, 8'h02)
		for (int m = 0; m < 8; m++)
		begin
			host_u.wr(8'h14, {m[0], m[1], 6'h00});
			msig = m[2];
			cyc(3); `CHK(fpwm, m[2] ? m[1] : m[0])
		end
		for (int g = 0; g < 16; g++)
		begin
			host_u.wr(8'h14, {3'h0, g[1], 3'h0, g[0]});
			sel = g[2];
			en = g[3]; // Either pin high leaves both idle states
			cyc(6); `CHK(ssel, g[0] ? g[2] : 1'b1)
			`CHK(liq, ~g[1] & ~g[2] & ~g[3])
			`CHK(slp, g[1] & ~g[2] & ~g[3])
		end
		host_u.wr(8'h16, 8'h01);
		thermal_shutdown = 1'b1;
		cyc(1); `CHK(conv, 1'b0)
		thermal_shutdown = 1'b0;
		cyc(1); `CHK({pup, conv}, 2'h3)
		cyc(1); `CHK(pup, 1'b0)
		host_u.rd(8'h16, q); `CHK(q, 8'h01)
		host_u.wr(8'h16, 8'h00);
		isc = 1'b1;
		cyc(1);
		isc = 1'b0;
		cyc(5); `CHK({pup, conv}, 2'h0)
		i_resetn = 1'b0;
		cyc(1);
		i_resetn = 1'b1;
		host_u.wr(8'h14, 8'h20);
		ramp = '{1'b1, 2'h0, 7'h02};
		cyc(1);
		ramp.start = 1'b0;
		`CHK(ract, 1'b1)
		cyc(2); `CHK(fpwm, 1'b1)
		cyc(11); `CHK(code, 7'h01)
		cyc(13); `CHK({ract, code}, 8'h02)
		host_u.wr(8'h14, 8'hC0);
		ramp = '{1'b1, 2'h1, 7'h00};
		cyc(1);
		ramp.start = 1'b0;
		cyc(2); `CHK(fpwm, 1'b0)
		cyc(53); `CHK({ract, code}, 8'h00)
		`CHK(fpwm, 1'b1)
		report_and_stop();
	end
endmodule
